// >>> logic/jlcs_pkg.sv
package jlcs_pkg;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [11:0] IDX_CONTROL = 12'h204;
  localparam logic [11:0] IDX_TEST = 12'h205;
  localparam logic [11:0] IDX_IDENT = 12'h206;
  localparam logic [11:0] IDX_FRAME_END_CHARACTER = 12'h207;
  localparam logic [11:0] IDX_STATUS = 12'h208;
  localparam logic [11:0] IDX_AUX = 12'h210;
  localparam logic [7:0] RST_CONTROL = 8'h02;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_IDENT = 8'h00;
  localparam logic [7:0] RST_FRAME_END_CHARACTER = 8'h00;
  localparam logic [2:0] RST_AUX = 3'h3;
  localparam int POS_SCR = 0;
  localparam int POS_FMT = 1;
  localparam int POS_SEL = 2;
  localparam int POS_EN = 0;
  localparam int POS_SWSYNC = 1;
  localparam int POS_TSEN = 2;
  localparam int POS_ALIGNMENT_FLAG = 3;
  localparam int POS_REALIGNED = 4;
  localparam logic [1:0] SEL_PIN = 2'h0;
  localparam logic [1:0] SEL_TSTAMP = 2'h1;
  localparam logic [3:0] TP_NORMAL = 4'h0;
  localparam logic [3:0] TP_PRBS7 = 4'h1;
  localparam logic [3:0] TP_PRBS15 = 4'h2;
  localparam logic [3:0] TP_PRBS23 = 4'h3;
  localparam logic [3:0] TP_RAMP = 4'h4;
  localparam logic [3:0] TP_TRANSPORT = 4'h5;
  localparam logic [3:0] TP_D215 = 4'h6;
  localparam logic [3:0] TP_K285 = 4'h7;
  localparam logic [3:0] TP_ILA = 4'h8;
  localparam logic [3:0] TP_RPAT = 4'h9;
  localparam logic [3:0] TP_LOW = 4'ha;
  localparam logic [3:0] TP_HIGH = 4'hb;
  localparam logic [7:0] CH_K287 = 8'hfc;
  localparam logic [7:0] CH_K281 = 8'h3c;
  localparam logic [7:0] CH_K285 = 8'hbc;
  localparam logic [7:0] CH_K280 = 8'h1c;
  localparam logic [7:0] CH_K284 = 8'h9c;
  localparam logic [7:0] CH_K283 = 8'h7c;
  localparam logic [7:0] CH_D215 = 8'hb5;
  localparam int DEF_FRAME_OCTETS = 2;
  localparam int DEF_FRAMES_PER_MF = 32;
endpackage

// >>> logic/jlcs_sync2.sv
`timescale 1ns/1ns
module jlcs_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) begin
      $error("jlcs_sync2 width must be at least one");
    end
  end

  // First stage feeds only the second one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// >>> logic/jlcs_lane_gen.sv
`timescale 1ns/1ns
module jlcs_lane_gen #(
  parameter logic [7:0] LINK_INDEX = 8'h00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic frame_end,
  input wire logic mf_start,
  input wire logic [3:0] test_code,
  input wire logic scramble_en,
  input wire logic twos_fmt,
  input wire logic [7:0] eof_char,
  input wire logic [7:0] device_id,
  input wire logic [7:0] sample_in,
  output logic [7:0] lane_data,
  output logic lane_k
);
  logic [22:0] lfsr_q;
  logic [14:0] scr_q;
  logic [7:0] ramp_q;
  logic [7:0] last_q;
  logic [3:0] ila_q;
  logic [7:0] fmt_byte;
  logic [7:0] scr_byte;
  logic [14:0] scr_next;
  logic [22:0] prbs_next;
  logic [7:0] data_d;
  logic k_d;

  function automatic logic [22:0] prbs_step(input logic [22:0] s, input logic [3:0] code);
    logic [22:0] v;
    logic fb;
    v = s;
    for (int i = 0; i < 8; i++) begin
      unique case (code)
        jlcs_pkg::TP_PRBS7: fb = v[6] ^ v[5];
        jlcs_pkg::TP_PRBS15: fb = v[14] ^ v[13];
        default: fb = v[22] ^ v[17];
      endcase
      v = {v[21:0], fb};
    end
    return v;
  endfunction

  // Self-synchronous 1 + x^14 + x^15 scrambler, MSB first
  function automatic logic [22:0] scramble(input logic [14:0] s, input logic [7:0] d);
    logic [14:0] v;
    logic [7:0] o;
    v = s;
    o = '0;
    for (int i = 7; i >= 0; i--) begin
      o[i] = d[i] ^ v[14] ^ v[13];
      v = {v[13:0], o[i]};
    end
    return {v, o};
  endfunction

  function automatic logic [7:0] rpat_byte(input logic [2:0] i);
    unique case (i)
      3'h0: return 8'hbe;
      3'h1: return 8'hd7;
      3'h2: return 8'h23;
      3'h3: return 8'h47;
      3'h4: return 8'h6b;
      3'h5: return 8'h8f;
      3'h6: return 8'hb3;
      default: return 8'h14;
    endcase
  endfunction

  always_comb begin
    prbs_next = prbs_step(lfsr_q, test_code);
    fmt_byte = twos_fmt ? sample_in : {~sample_in[7], sample_in[6:0]};
    {scr_next, scr_byte} = scramble(scr_q, fmt_byte);
    data_d = fmt_byte;
    k_d = 1'b0;
    unique case (test_code)
      jlcs_pkg::TP_PRBS7, jlcs_pkg::TP_PRBS15, jlcs_pkg::TP_PRBS23: begin
        data_d = prbs_next[7:0];
      end
      jlcs_pkg::TP_RAMP: data_d = ramp_q;
      jlcs_pkg::TP_TRANSPORT: data_d = {ila_q, ramp_q[3:0]};
      jlcs_pkg::TP_D215: data_d = jlcs_pkg::CH_D215;
      jlcs_pkg::TP_K285: begin
        data_d = jlcs_pkg::CH_K285;
        k_d = 1'b1;
      end
      jlcs_pkg::TP_ILA: begin
        // Each 16-octet ila_q cycle carries the identifier in its eleventh octet, after K28.0 and K28.4
        k_d = 1'b1;
        unique case (ila_q)
          4'h0, 4'h8: data_d = jlcs_pkg::CH_K280;
          4'h9: data_d = jlcs_pkg::CH_K284;
          4'ha: begin
            data_d = device_id + LINK_INDEX;
            k_d = 1'b0;
          end
          4'h7, 4'hf: data_d = jlcs_pkg::CH_K283;
          default: begin
            data_d = 8'h00;
            k_d = 1'b0;
          end
        endcase
      end
      jlcs_pkg::TP_RPAT: data_d = rpat_byte(ila_q[2:0]);
      jlcs_pkg::TP_LOW: data_d = 8'h00;
      jlcs_pkg::TP_HIGH: data_d = 8'hff;
      default: begin
        // Normal path; reserved codes fall here as well
        data_d = scramble_en ? scr_byte : fmt_byte;
        // Unscrambled: repeat of last frame-end octet; scrambled: octet equal to K28.7 code
        if (frame_end && ((!scramble_en && fmt_byte == last_q) ||
            (scramble_en && scr_byte == jlcs_pkg::CH_K287))) begin
          data_d = eof_char;
          k_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_data <= 8'h00;
      lane_k <= 1'b0;
      lfsr_q <= 23'h7fffff;
      scr_q <= 15'h7fff;
      ramp_q <= 8'h00;
      last_q <= 8'h00;
      ila_q <= 4'h0;
    end else if (!run) begin
      lane_data <= 8'h00;
      lane_k <= 1'b0;
      lfsr_q <= 23'h7fffff;
      scr_q <= 15'h7fff;
      ramp_q <= 8'h00;
      last_q <= 8'h00;
      ila_q <= 4'h0;
    end else begin
      lane_data <= data_d;
      lane_k <= k_d;
      lfsr_q <= prbs_next;
      ramp_q <= ramp_q + 8'h01;
      if (scramble_en) begin
        scr_q <= scr_next;
      end
      if (frame_end) begin
        last_q <= fmt_byte;
      end
      ila_q <= mf_start ? 4'h0 : ila_q + 4'h1;
    end
  end
endmodule

// >>> logic/jlcs_regs.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
module jlcs_regs #(
  parameter int FRAME_OCTETS = jlcs_pkg::DEF_FRAME_OCTETS,
  parameter int FRAMES_PER_MF = jlcs_pkg::DEF_FRAMES_PER_MF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic single_ended_sync_pin,
  input wire logic timestamp_diff_input,
  input wire logic sysref_pin,
  input wire logic pll_locked_pin,
  input wire logic link_up_pin,
  input wire logic [7:0] sample_a,
  input wire logic [7:0] sample_b,
  output logic [7:0] lane_a_data,
  output logic lane_a_k,
  output logic [7:0] lane_b_data,
  output logic lane_b_k,
  output logic link_sync_request_n,
  output logic link_reset_n,
  output logic serializer_power_down,
  output logic link_clock_enable
);
  localparam logic [13:0] ADDR_CONTROL = {jlcs_pkg::IDX_CONTROL, 2'b00};
  localparam logic [13:0] ADDR_TEST = {jlcs_pkg::IDX_TEST, 2'b00};
  localparam logic [13:0] ADDR_IDENT = {jlcs_pkg::IDX_IDENT, 2'b00};
  localparam logic [13:0] ADDR_FRAME_END_CHARACTER = {jlcs_pkg::IDX_FRAME_END_CHARACTER, 2'b00};
  localparam logic [13:0] ADDR_STATUS = {jlcs_pkg::IDX_STATUS, 2'b00};
  localparam logic [13:0] ADDR_AUX = {jlcs_pkg::IDX_AUX, 2'b00};
  localparam logic [7:0] OCT_LAST = 8'(FRAME_OCTETS - 1);
  localparam logic [7:0] FRM_LAST = 8'(FRAMES_PER_MF - 1);

  initial begin
    if (FRAME_OCTETS < 1 || FRAME_OCTETS > 256 || FRAMES_PER_MF < 1 || FRAMES_PER_MF > 256) begin
      $error("jlcs_regs frame geometry out of range");
    end
  end

  logic [7:0] control_q;
  logic [7:0] test_q;
  logic [7:0] ident_q;
  logic [7:0] frame_end_character_q;
  logic [2:0] aux_q;
  logic realigned_q;
  logic alignment_flag_q;
  logic seen_q;
  logic sync_n_q;
  logic sysref_prev_q;
  logic [7:0] oct_q;
  logic [7:0] frm_q;
  logic [7:0] eof_char_q;
  logic [4:0] pins_s;
  logic se_sync_s;
  logic ts_s;
  logic sysref_s;
  logic pll_s;
  logic link_up_s;
  logic access;
  logic wr;
  logic wr_byte;
  logic link_en;
  logic sysref_rise;
  logic mf_last;
  logic frame_end;
  logic mf_start;
  logic sel_pin_n;
  logic [7:0] status_byte;

  function automatic logic addr_mapped(input logic [13:0] a);
    return a == ADDR_CONTROL || a == ADDR_TEST || a == ADDR_IDENT || a == ADDR_FRAME_END_CHARACTER ||
           a == ADDR_STATUS || a == ADDR_AUX;
  endfunction

  jlcs_sync2 #(
    .WIDTH(5)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({link_up_pin, pll_locked_pin, sysref_pin, timestamp_diff_input, single_ended_sync_pin}),
    .sync_out(pins_s)
  );

  assign se_sync_s = pins_s[0];
  assign ts_s = pins_s[1];
  assign sysref_s = pins_s[2];
  assign pll_s = pins_s[3];
  assign link_up_s = pins_s[4];

  assign access = psel && penable;
  // The write lands at the edge where the master samples pready high
  assign wr = access && pready && pwrite;
  assign wr_byte = wr && pstrb[0];
  assign link_en = aux_q[jlcs_pkg::POS_EN];
  assign sysref_rise = sysref_s && !sysref_prev_q;
  assign mf_last = oct_q == OCT_LAST && frm_q == FRM_LAST;
  assign frame_end = oct_q == OCT_LAST;
  assign mf_start = oct_q == 8'h00 && frm_q == 8'h00;
  assign status_byte = {1'b0, link_up_s, sync_n_q, realigned_q, alignment_flag_q, pll_s, 2'b00};

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !addr_mapped(paddr);
      if (access && !pready && !pwrite) begin
        unique case (paddr)
          ADDR_CONTROL: prdata <= {24'h000000, control_q};
          ADDR_TEST: prdata <= {24'h000000, test_q};
          ADDR_IDENT: prdata <= {24'h000000, ident_q};
          ADDR_FRAME_END_CHARACTER: prdata <= {24'h000000, frame_end_character_q};
          ADDR_STATUS: prdata <= {24'h000000, status_byte};
          ADDR_AUX: prdata <= {29'h00000000, aux_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Settings are not shadowed: changing them while the link runs glitches lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= jlcs_pkg::RST_CONTROL;
      test_q <= jlcs_pkg::RST_TEST;
      ident_q <= jlcs_pkg::RST_IDENT;
      frame_end_character_q <= jlcs_pkg::RST_FRAME_END_CHARACTER;
      aux_q <= jlcs_pkg::RST_AUX;
    end else if (wr_byte) begin
      unique case (paddr)
        ADDR_CONTROL: control_q <= pwdata[7:0];
        ADDR_TEST: test_q <= pwdata[7:0];
        ADDR_IDENT: ident_q <= {pwdata[7:1], 1'b0};
        ADDR_FRAME_END_CHARACTER: frame_end_character_q <= pwdata[7:0];
        ADDR_AUX: aux_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (control_q[jlcs_pkg::POS_SEL +: 2])
      jlcs_pkg::SEL_PIN: sel_pin_n = se_sync_s;
      jlcs_pkg::SEL_TSTAMP: sel_pin_n = aux_q[jlcs_pkg::POS_TSEN] ? ts_s : 1'b1;
      default: sel_pin_n = 1'b1;
    endcase
  end

  // Software request works under any selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_n_q <= 1'b1;
      link_sync_request_n <= 1'b1;
    end else begin
      sync_n_q <= sel_pin_n && aux_q[jlcs_pkg::POS_SWSYNC];
      link_sync_request_n <= sel_pin_n && aux_q[jlcs_pkg::POS_SWSYNC];
    end
  end

  // Reserved code 3 falls back to the compliant comma
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eof_char_q <= jlcs_pkg::CH_K287;
    end else begin
      unique case (frame_end_character_q[1:0])
        2'h1: eof_char_q <= jlcs_pkg::CH_K281;
        2'h2: eof_char_q <= jlcs_pkg::CH_K285;
        default: eof_char_q <= jlcs_pkg::CH_K287;
      endcase
    end
  end

  // Multiframe counter; an in-phase sysref lands on the last octet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oct_q <= 8'h00;
      frm_q <= 8'h00;
      seen_q <= 1'b0;
      sysref_prev_q <= 1'b0;
    end else begin
      sysref_prev_q <= sysref_s;
      if (!link_en) begin
        oct_q <= 8'h00;
        frm_q <= 8'h00;
        seen_q <= 1'b0;
      end else if (sysref_rise || mf_last) begin
        oct_q <= 8'h00;
        frm_q <= 8'h00;
        seen_q <= seen_q || sysref_rise;
      end else if (frame_end) begin
        oct_q <= 8'h00;
        frm_q <= frm_q + 8'h01;
      end else begin
        oct_q <= oct_q + 8'h01;
      end
    end
  end

  // Set beats a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alignment_flag_q <= 1'b0;
      realigned_q <= 1'b0;
    end else begin
      if (link_en && sysref_rise && !seen_q) begin
        alignment_flag_q <= 1'b1;
      end else if (wr_byte && paddr == ADDR_STATUS && pwdata[jlcs_pkg::POS_ALIGNMENT_FLAG]) begin
        alignment_flag_q <= 1'b0;
      end
      if (link_en && sysref_rise && seen_q && !mf_last) begin
        realigned_q <= 1'b1;
      end else if (wr_byte && paddr == ADDR_STATUS && pwdata[jlcs_pkg::POS_REALIGNED]) begin
        realigned_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_reset_n <= 1'b0;
      serializer_power_down <= 1'b1;
      link_clock_enable <= 1'b0;
    end else begin
      link_reset_n <= link_en;
      serializer_power_down <= !link_en;
      link_clock_enable <= link_en;
    end
  end

  jlcs_lane_gen #(
    .LINK_INDEX(8'h00)
  ) u_lane_a (
    .pclk(pclk),
    .presetn(presetn),
    .run(link_en),
    .frame_end(frame_end),
    .mf_start(mf_start),
    .test_code(test_q[3:0]),
    .scramble_en(control_q[jlcs_pkg::POS_SCR]),
    .twos_fmt(control_q[jlcs_pkg::POS_FMT]),
    .eof_char(eof_char_q),
    .device_id(ident_q),
    .sample_in(sample_a),
    .lane_data(lane_a_data),
    .lane_k(lane_a_k)
  );

  jlcs_lane_gen #(
    .LINK_INDEX(8'h01)
  ) u_lane_b (
    .pclk(pclk),
    .presetn(presetn),
    .run(link_en),
    .frame_end(frame_end),
    .mf_start(mf_start),
    .test_code(test_q[3:0]),
    .scramble_en(control_q[jlcs_pkg::POS_SCR]),
    .twos_fmt(control_q[jlcs_pkg::POS_FMT]),
    .eof_char(eof_char_q),
    .device_id(ident_q),
    .sample_in(sample_b),
    .lane_data(lane_b_data),
    .lane_k(lane_b_k)
  );

  pready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready did not pulse one cycle after access start");

  unmapped_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !addr_mapped(paddr) |=> pslverr && pready)
    else $error("unmapped access not flagged");

  ident_even_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_byte && paddr == ADDR_IDENT |=> ident_q == {$past(pwdata[7:1]), 1'b0})
    else $error("identifier bit zero not cleared on write");

  sync_soft_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    control_q[3:2] == 2'h2 && aux_q[1] |=> sync_n_q && link_sync_request_n)
    else $error("sync pins not ignored under software select");

  sync_soft_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    !aux_q[1] |=> !sync_n_q && !status_byte[5])
    else $error("software sync request not shown as asserted");

  alignment_flag_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    link_en && sysref_rise && !seen_q |=> alignment_flag_q && seen_q && oct_q == 8'h00)
    else $error("first sysref did not set alignment");

  realign_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    link_en && sysref_rise && seen_q && !mf_last |=> realigned_q)
    else $error("realignment flag not set");

  disabled_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !link_en |=> oct_q == 8'h00 && frm_q == 8'h00 && !lane_a_k && serializer_power_down)
    else $error("disabled link not held in reset");

  hold_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (link_en && test_q[3:0] == 4'ha) [*2] |=> lane_a_data == 8'h00 && lane_b_data == 8'h00)
    else $error("serial outputs not held low");

  hold_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (link_en && test_q[3:0] == 4'hb) [*2] |=> lane_a_data == 8'hff && !lane_b_k)
    else $error("serial outputs not held high");
endmodule

// >>> tb/jlcs_rx_model.sv
`timescale 1ns/1ns
module jlcs_rx_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic want_sync,
  input wire logic [7:0] lane_data,
  input wire logic lane_k,
  output logic sync_n,
  output logic [7:0] rx_data,
  output logic rx_k
);
  // Receiver registers each lane octet; a resync request pulls its line low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_n <= 1'b1;
      rx_data <= 8'h00;
      rx_k <= 1'b0;
    end else begin
      sync_n <= !want_sync;
      rx_data <= lane_data;
      rx_k <= lane_k;
    end
  end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL %s expected %h seen %h", n, e, g); end end
module testbench;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, sysref, pll, lup, want_sync, sync_n, rx_k;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, la_k, lb_k, sreq_n, lrst_n, spd, lclk_en;
  logic [7:0] la, lb, rx_data, r;
  logic e;
  logic ts;
  logic [3:0] pstrb;
  logic [7:0] smp_a;
  int err_count = 0;
  int check_count = 0;
  int hits;
  logic [3:0] tc [4] = '{4'h6, 4'h7, 4'ha, 4'hb};
  logic [7:0] td [4] = '{8'hb5, 8'hbc, 8'h00, 8'hff};
  logic tk [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  localparam logic [11:0] AUX = jlcs_pkg::IDX_AUX;

  always #5 pclk = ~pclk;

  // Sixteen-octet multiframe so the ten-cycle gap between sysref rises fits in one multiframe
  jlcs_regs #(.FRAME_OCTETS(2), .FRAMES_PER_MF(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .single_ended_sync_pin(sync_n), .timestamp_diff_input(ts),
    .sysref_pin(sysref), .pll_locked_pin(pll), .link_up_pin(lup), .sample_a(smp_a), .sample_b(8'h00),
    .lane_a_data(la), .lane_a_k(la_k), .lane_b_data(lb), .lane_b_k(lb_k), .link_sync_request_n(sreq_n),
    .link_reset_n(lrst_n), .serializer_power_down(spd), .link_clock_enable(lclk_en));

  jlcs_rx_model i_rx (.pclk(pclk), .presetn(presetn), .want_sync(want_sync), .lane_data(la),
    .lane_k(la_k), .sync_n(sync_n), .rx_data(rx_data), .rx_k(rx_k));

  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      give_verdict();
    end
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string n, input logic [11:0] idx, input logic [7:0] x);
    apb(1'b0, idx, 8'h00);
    `CHK(n, x, r)
  endtask

  task automatic lane_run(input logic [7:0] c, input logic [7:0] t);
    apb(1'b1, AUX, 8'h00);
    apb(1'b1, jlcs_pkg::IDX_CONTROL, c);
    apb(1'b1, jlcs_pkg::IDX_TEST, t);
    apb(1'b1, AUX, 8'h03);
    repeat (4) @(posedge pclk);
  endtask

  // Constant samples repeat at frame ends, so commas must show up there
  task automatic lane_chk(input string n, input logic [7:0] x);
    int k;
    k = 0;
    repeat (16) begin
      @(posedge pclk);
      if (la_k === 1'b1) begin
        k++;
        `CHK("comma", jlcs_pkg::CH_K287, la)
      end else begin
        `CHK(n, x, la)
      end
    end
    `CHK("comma seen", 1'b1, k > 0)
    `CHK("comma sparse", 1'b1, k <= 8)
  endtask

  task automatic give_verdict();
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, sysref, want_sync} = '0;
    {pll, lup} = 2'b11;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    ts = 1'b1;
    smp_a = 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd("control", jlcs_pkg::IDX_CONTROL, 8'h02);
    rd("test", jlcs_pkg::IDX_TEST, 8'h00);
    rd("ident", jlcs_pkg::IDX_IDENT, 8'h00);
    rd("frame_end_character", jlcs_pkg::IDX_FRAME_END_CHARACTER, 8'h00);
    apb(1'b0, 12'h3ff, 8'h00);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 8'h00, r)
    // Settings only move while the link is held off
    apb(1'b1, AUX, 8'h00);
    apb(1'b1, jlcs_pkg::IDX_IDENT, 8'h57);
    rd("ident odd", jlcs_pkg::IDX_IDENT, 8'h56);
    pstrb <= 4'h0;
    apb(1'b1, jlcs_pkg::IDX_IDENT, 8'h22);
    pstrb <= 4'hf;
    rd("ident strobe", jlcs_pkg::IDX_IDENT, 8'h56);
    apb(1'b1, jlcs_pkg::IDX_FRAME_END_CHARACTER, 8'h02);
    rd("frame_end_character rw", jlcs_pkg::IDX_FRAME_END_CHARACTER, 8'h02);
    apb(1'b1, jlcs_pkg::IDX_FRAME_END_CHARACTER, 8'h00);
    apb(1'b1, AUX, 8'h03);
    // Pin sync path, then software-only select ignores the pin
    want_sync <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("sync pin", 1'b0, sreq_n)
    rd("sync state", jlcs_pkg::IDX_STATUS, 8'h44);
    apb(1'b1, AUX, 8'h00);
    apb(1'b1, jlcs_pkg::IDX_CONTROL, 8'h0a);
    apb(1'b1, AUX, 8'h03);
    repeat (6) @(posedge pclk);
    `CHK("sync sel2", 1'b1, sreq_n)
    apb(1'b1, AUX, 8'h01);
    repeat (4) @(posedge pclk);
    `CHK("sync sw", 1'b0, sreq_n)
    apb(1'b1, AUX, 8'h03);
    want_sync <= 1'b0;
    // Timestamp select needs its receiver enabled
    ts <= 1'b0;
    apb(1'b1, AUX, 8'h00);
    apb(1'b1, jlcs_pkg::IDX_CONTROL, 8'h06);
    apb(1'b1, AUX, 8'h03);
    repeat (6) @(posedge pclk);
    `CHK("ts recv off", 1'b1, sreq_n)
    apb(1'b1, AUX, 8'h07);
    repeat (6) @(posedge pclk);
    `CHK("ts recv on", 1'b0, sreq_n)
    ts <= 1'b1;
    // Fixed lane patterns, checked at the receiver
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, AUX, 8'h00);
      repeat (2) @(posedge pclk);
      `CHK("link off", 3'b010, {lrst_n, spd, lclk_en})
      apb(1'b1, jlcs_pkg::IDX_TEST, {4'h0, tc[i]});
      apb(1'b1, AUX, 8'h03);
      repeat (6) @(posedge pclk);
      `CHK("pattern data", td[i], rx_data)
      `CHK("pattern k", tk[i], rx_k)
    end
    apb(1'b1, AUX, 8'h00);
    apb(1'b1, jlcs_pkg::IDX_TEST, 8'h08);
    apb(1'b1, AUX, 8'h03);
    hits = 0;
    repeat (40) begin
      @(posedge pclk);
      if (la_k === 1'b0 && la === 8'h56) begin
        hits++;
        `CHK("ila id b", 8'h57, lb)
      end
    end
    `CHK("ila id a", 1'b1, hits > 0)
    // Normal path in both sample formats, reserved code acts as normal
    smp_a <= 8'h12;
    lane_run(8'h0a, 8'h00);
    lane_chk("normal twos", 8'h12);
    lane_run(8'h08, 8'h0c);
    lane_chk("reserved offset", 8'h92);
    // First sysref after enable marks alignment; write one clears it
    sysref <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, jlcs_pkg::IDX_STATUS, 8'h00);
    `CHK("status", 5'b11011, r[6:2])
    apb(1'b1, jlcs_pkg::IDX_STATUS, 8'h18);
    apb(1'b0, jlcs_pkg::IDX_STATUS, 8'h00);
    `CHK("status w1c", 5'b11001, r[6:2])
    // Two rises ten cycles apart: the second cannot meet the multiframe end
    repeat (2) begin
      sysref <= 1'b0;
      repeat (5) @(posedge pclk);
      sysref <= 1'b1;
      repeat (5) @(posedge pclk);
    end
    apb(1'b0, jlcs_pkg::IDX_STATUS, 8'h00);
    `CHK("realigned", 5'b11101, r[6:2])
    apb(1'b1, jlcs_pkg::IDX_STATUS, 8'h10);
    apb(1'b0, jlcs_pkg::IDX_STATUS, 8'h00);
    `CHK("realign w1c", 5'b11001, r[6:2])
    give_verdict();
  end

  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule
